/* File: src/blit_fmt_pkg.sv */
package blit_fmt_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_SRC_FMT = 12'h000;
  localparam logic [11:0] OFS_DST_FMT = 12'h004;
  localparam logic [11:0] OFS_CLIP0_MIN = 12'h008;
  localparam logic [11:0] OFS_CLIP0_MAX = 12'h00C;
  localparam logic [11:0] OFS_CLIP1_MIN = 12'h010;
  localparam logic [11:0] OFS_CLIP1_MAX = 12'h014;
  localparam logic [11:0] OFS_FG_COLOR = 12'h018;
  localparam logic [11:0] OFS_BG_COLOR = 12'h01C;
  localparam logic [11:0] OFS_COMMAND = 12'h020;
  localparam logic [11:0] OFS_GEOMETRY = 12'h024;
  localparam logic [11:0] OFS_STRIDE_STAT = 12'h028;

  // Writable bit masks, reserved bits clear
  localparam logic [31:0] MASK_SRC_FMT = 32'h00FF3FFF;
  localparam logic [31:0] MASK_DST_FMT = 32'h00073FFF;
  localparam logic [31:0] MASK_CLIP = 32'h0FFF0FFF;
  localparam logic [31:0] MASK_COMMAND = 32'h00000001;
  localparam logic [31:0] MASK_GEOMETRY = 32'h00031FFF;

  // Values after reset
  localparam logic [31:0] RST_REG = 32'h00000000;

  // Field positions
  localparam int STRIDE_LSB = 0;
  localparam int TILE_STRIDE_MSB = 6;
  localparam int FMT_LSB = 16;
  localparam int BYTE_SWZ_BIT = 20;
  localparam int WORD_SWZ_BIT = 21;
  localparam int PACK_LSB = 22;
  localparam int CLIP_Y_LSB = 16;
  localparam int CLIP_SEL_BIT = 0;
  localparam int SRC_TILED_BIT = 16;
  localparam int DST_TILED_BIT = 17;
  localparam int DST_STAT_LSB = 16;

  // Source color format codes
  localparam logic [3:0] SRC_MONO = 4'h0;
  localparam logic [3:0] SRC_PAL8 = 4'h1;
  localparam logic [3:0] SRC_RGB16 = 4'h3;
  localparam logic [3:0] SRC_RGB24 = 4'h4;
  localparam logic [3:0] SRC_RGB32 = 4'h5;
  localparam logic [3:0] SRC_YUYV = 4'h8;
  localparam logic [3:0] SRC_UYVY = 4'h9;

  // Destination depth codes
  localparam logic [2:0] DST_D8 = 3'h1;
  localparam logic [2:0] DST_D16 = 3'h3;
  localparam logic [2:0] DST_D24 = 3'h4;
  localparam logic [2:0] DST_D32 = 3'h5;

  // Source packing codes
  localparam logic [1:0] PACK_NONE = 2'h0;
  localparam logic [1:0] PACK_BYTE = 2'h1;
  localparam logic [1:0] PACK_WORD = 2'h2;
  localparam logic [1:0] PACK_DWORD = 2'h3;

  // Incoming source pixel word with its place
  typedef struct packed {
    logic [31:0] data;
    logic [4:0] idx;
    logic [11:0] x;
    logic [11:0] y;
  } pix_in_t;

  // Converted destination pixel
  typedef struct packed {
    logic [31:0] data;
    logic [11:0] x;
    logic [11:0] y;
    logic write;
    logic supported;
  } pix_out_t;

endpackage

/* File: src/blit_surface_format_clip.sv */
`timescale 1ns/1ps
// Function
// (R1) Linear stride counts bytes, any format
// (R2) Tiled stride uses only low seven bits
// (R3) 32bpp is RGB plus spare byte
// (R4) Bits 20/21 enable host byte/word swap
// (R5) Byte swap first, then word swap
// (R6) Packing zero uses stride field, else width
// (R7) Packing rounds bytes to 1,2,4 multiple
// (R8) Software never packs a tiled source
// (R9) Software keeps YUV linear stride dword-aligned
// (R10) Widening replicates channel msbs into lsbs
// (R11) Narrowing drops channel lsbs and alpha
// (R12) Non-32bpp source to 32bpp: zero alpha; mono takes alpha from the color registers
// (R13) Mono uses colors, YUV to RGB
// (R14) Source format field codes decoded
// (R15) Destination depth field codes decoded
// (R16) Stride held in low fourteen bits
// (R17) Mono leftmost pixel is bit 7
// (R18) UYVY bytes: U, Ya, V, Yb
// (R19) Two clip sets, select bit chooses
// (R20) Write inside min inclusive, max exclusive
// (R21) Set0 minimum holds x in bits 11:0
// (R22) Clip y bound at bits 27:16
// (R23) Reserved bits ignored, read as zero
module blit_surface_format_clip
  import blit_fmt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic host_valid,
  input wire logic [31:0] host_data,
  output logic swz_valid,
  output logic [31:0] swz_data,
  input wire logic pix_valid,
  input wire pix_in_t pix_in,
  output logic out_valid,
  output pix_out_t pix_out,
  output logic [13:0] src_stride,
  output logic [13:0] dst_stride
);

  // Whole block state
  typedef struct packed {
    logic [31:0] src_fmt;
    logic [31:0] dst_fmt;
    logic [31:0] clip0_min;
    logic [31:0] clip0_max;
    logic [31:0] clip1_min;
    logic [31:0] clip1_max;
    logic [31:0] fg;
    logic [31:0] bg;
    logic [31:0] cmd;
    logic [31:0] geom;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    logic [13:0] src_stride;
    logic [13:0] dst_stride;
    logic swz_valid;
    logic [31:0] swz_data;
    logic out_valid;
    pix_out_t out;
  } state_t;

  state_t st_r; // Registered state
  state_t st_nxt; // Next state

  // Byte and word swizzle of a host word
  function automatic logic [31:0] swizzle(input logic [31:0] d, input logic bs,
                                          input logic ws);
    logic [31:0] t;
    t = bs ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    swizzle = ws ? {t[15:0], t[31:16]} : t;
  endfunction

  // Clamp a signed sum to one 8-bit channel
  function automatic logic [7:0] clamp8(input logic signed [19:0] v);
    if (v < 20'sd0) begin
      clamp8 = 8'h00;
    end else if (v > 20'sd255) begin
      clamp8 = 8'hFF;
    end else begin
      clamp8 = v[7:0];
    end
  endfunction

  // Studio-range YUV to RGB888
  function automatic logic [23:0] yuv2rgb(input logic [7:0] y, input logic [7:0] u,
                                          input logic [7:0] v);
    logic signed [19:0] c;
    logic signed [19:0] d;
    logic signed [19:0] e;
    c = $signed({12'h000, y}) - 20'sd16;
    d = $signed({12'h000, u}) - 20'sd128;
    e = $signed({12'h000, v}) - 20'sd128;
    yuv2rgb = {clamp8((20'sd298 * c + 20'sd409 * e + 20'sd128) >>> 8),
               clamp8((20'sd298 * c - 20'sd100 * d - 20'sd208 * e + 20'sd128) >>> 8),
               clamp8((20'sd298 * c + 20'sd516 * d + 20'sd128) >>> 8)};
  endfunction

  // Clip bounds check, min inclusive and max exclusive
  function automatic logic in_clip(input logic [31:0] mn, input logic [31:0] mx,
                                   input logic [11:0] x, input logic [11:0] y);
    in_clip = (x >= mn[11:0]) && (x < mx[11:0]) &&
              (y >= mn[CLIP_Y_LSB+:12]) && (y < mx[CLIP_Y_LSB+:12]);
  endfunction

  // Register read mux, reserved bits already zero
  function automatic logic [31:0] read_reg(input state_t s, input logic [11:0] a);
    case (a)
      OFS_SRC_FMT: read_reg = s.src_fmt;
      OFS_DST_FMT: read_reg = s.dst_fmt;
      OFS_CLIP0_MIN: read_reg = s.clip0_min;
      OFS_CLIP0_MAX: read_reg = s.clip0_max;
      OFS_CLIP1_MIN: read_reg = s.clip1_min;
      OFS_CLIP1_MAX: read_reg = s.clip1_max;
      OFS_FG_COLOR: read_reg = s.fg;
      OFS_BG_COLOR: read_reg = s.bg;
      OFS_COMMAND: read_reg = s.cmd;
      OFS_GEOMETRY: read_reg = s.geom;
      OFS_STRIDE_STAT: read_reg = {2'b00, s.dst_stride, 2'b00, s.src_stride};
      default: read_reg = 32'h00000000;
    endcase
  endfunction

  // Slave is always ready with an OKAY answer
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign swz_valid = st_r.swz_valid;
  assign swz_data = st_r.swz_data;
  assign out_valid = st_r.out_valid;
  assign pix_out = st_r.out;
  assign src_stride = st_r.src_stride;
  assign dst_stride = st_r.dst_stride;

  // Decoded fields
  logic [3:0] sfmt; // Source format code
  logic [2:0] dfmt; // Destination depth code
  logic [1:0] pack; // Source packing code
  logic taken; // AHB address phase accepted
  logic [5:0] bpp; // Source bits per pixel
  logic [18:0] row_bits; // Bits in one blit row
  logic [15:0] row_bytes; // Bytes in one blit row
  logic [15:0] packed_stride; // Width-based stride
  logic [23:0] rgb; // Source as RGB888
  logic [7:0] alpha; // Source alpha byte
  logic [7:0] ya; // Left luma
  logic [7:0] yb; // Right luma
  logic [7:0] cu; // Chroma U
  logic [7:0] cv; // Chroma V
  logic conv_ok; // Format pair supported
  logic [31:0] conv; // Converted pixel
  logic mono_bit; // Selected mono bit

  // Next state of registers, strides and pixel path
  always_comb begin
    st_nxt = st_r;
    sfmt = st_r.src_fmt[FMT_LSB+:4];
    dfmt = st_r.dst_fmt[FMT_LSB+:3];
    pack = st_r.src_fmt[PACK_LSB+:2];
    taken = hsel && hready && htrans[1];
    // Data phase of a write commits masked data
    // (R23) Reserved bits dropped
    if (st_r.wr_pend) begin
      case (st_r.wr_addr)
        OFS_SRC_FMT: st_nxt.src_fmt = hwdata & MASK_SRC_FMT;
        OFS_DST_FMT: st_nxt.dst_fmt = hwdata & MASK_DST_FMT;
        // (R21) (R22) Clip x and y fields
        OFS_CLIP0_MIN: st_nxt.clip0_min = hwdata & MASK_CLIP;
        OFS_CLIP0_MAX: st_nxt.clip0_max = hwdata & MASK_CLIP;
        OFS_CLIP1_MIN: st_nxt.clip1_min = hwdata & MASK_CLIP;
        OFS_CLIP1_MAX: st_nxt.clip1_max = hwdata & MASK_CLIP;
        OFS_FG_COLOR: st_nxt.fg = hwdata;
        OFS_BG_COLOR: st_nxt.bg = hwdata;
        OFS_COMMAND: st_nxt.cmd = hwdata & MASK_COMMAND;
        OFS_GEOMETRY: st_nxt.geom = hwdata & MASK_GEOMETRY;
        default: st_nxt.cmd = st_r.cmd; // Unmapped or read-only
      endcase
    end
    // Address phase capture; reads see a write just committed
    st_nxt.wr_pend = taken && hwrite;
    st_nxt.wr_addr = taken ? haddr[11:0] : st_r.wr_addr;
    if (taken && !hwrite) begin
      st_nxt.rdata = (haddr[31:12] == 20'h00000) ? read_reg(st_nxt, haddr[11:0]) : 32'h0;
    end
    // (R14) Source depth per format code
    case (sfmt)
      SRC_MONO: bpp = 6'd1;
      SRC_PAL8: bpp = 6'd8;
      SRC_RGB24: bpp = 6'd24;
      // (R3) 32bpp carries a spare byte
      SRC_RGB32: bpp = 6'd32;
      default: bpp = 6'd16; // 16bpp and both YUV
    endcase
    row_bits = 19'(st_r.geom[12:0]) * 19'(bpp);
    row_bytes = 16'((row_bits + 19'd7) >> 3);
    // (R7) Round row bytes up to alignment
    case (pack)
      PACK_WORD: packed_stride = (row_bytes + 16'd1) & 16'hFFFE;
      PACK_DWORD: packed_stride = (row_bytes + 16'd3) & 16'hFFFC;
      default: packed_stride = row_bytes;
    endcase
    // (R2) Tiled strides keep the low seven bits
    if (st_r.geom[SRC_TILED_BIT]) begin
      // (R8) Packing never combined with tiled source
      st_nxt.src_stride = {7'h00, st_r.src_fmt[TILE_STRIDE_MSB:STRIDE_LSB]};
    end else if (pack == PACK_NONE) begin
      // (R1) (R6) (R16) Linear byte stride from field
      st_nxt.src_stride = st_r.src_fmt[13:STRIDE_LSB];
    end else begin
      // (R6) Stride from blit width
      st_nxt.src_stride = packed_stride[13:0];
    end
    // (R2) (R16) Destination stride likewise
    st_nxt.dst_stride = st_r.geom[DST_TILED_BIT] ?
                        {7'h00, st_r.dst_fmt[TILE_STRIDE_MSB:STRIDE_LSB]} :
                        st_r.dst_fmt[13:STRIDE_LSB];
    // (R4) (R5) Host port swizzle, byte then word
    st_nxt.swz_valid = host_valid;
    if (host_valid) begin
      st_nxt.swz_data = swizzle(host_data, st_r.src_fmt[BYTE_SWZ_BIT],
                                st_r.src_fmt[WORD_SWZ_BIT]);
    end
    // (R17) Leftmost mono pixel is bit 7 of byte 0
    mono_bit = pix_in.data[{pix_in.idx[4:3], ~pix_in.idx[2:0]}];
    // (R18) UYVY byte order, else YUYV order
    if (sfmt == SRC_UYVY) begin
      cu = pix_in.data[7:0];
      ya = pix_in.data[15:8];
      cv = pix_in.data[23:16];
      yb = pix_in.data[31:24];
    end else begin
      ya = pix_in.data[7:0];
      cu = pix_in.data[15:8];
      yb = pix_in.data[23:16];
      cv = pix_in.data[31:24];
    end
    // Source to RGB888 plus alpha
    rgb = 24'h000000;
    alpha = 8'h00;
    conv_ok = (dfmt == DST_D16) || (dfmt == DST_D24) || (dfmt == DST_D32);
    case (sfmt)
      SRC_MONO: begin
        conv_ok = conv_ok || (dfmt == DST_D8);
      end
      SRC_PAL8: begin
        conv_ok = (dfmt == DST_D8);
      end
      SRC_RGB16: begin
        // (R10) Replicate msbs into added lsbs
        rgb = {pix_in.data[15:11], pix_in.data[15:13], pix_in.data[10:5],
               pix_in.data[10:9], pix_in.data[4:0], pix_in.data[4:2]};
      end
      SRC_RGB24: begin
        rgb = pix_in.data[23:0];
      end
      SRC_RGB32: begin
        rgb = pix_in.data[23:0];
        alpha = pix_in.data[31:24];
      end
      SRC_YUYV, SRC_UYVY: begin
        // (R13) YUV converted to RGB
        rgb = pix_in.idx[0] ? yuv2rgb(yb, cu, cv) : yuv2rgb(ya, cu, cv);
      end
      default: begin
        conv_ok = 1'b0;
      end
    endcase
    // Pack into destination depth
    case (dfmt)
      // (R11) Drop surplus lsbs and alpha
      DST_D16: conv = {16'h0000, rgb[23:19], rgb[15:10], rgb[7:3]};
      DST_D24: conv = {8'h00, rgb};
      // (R12) Alpha zero unless source is 32bpp or mono
      DST_D32: conv = {alpha, rgb};
      default: conv = {24'h000000, pix_in.data[7:0]};
    endcase
    // (R13) Mono expands through color registers
    if (sfmt == SRC_MONO) begin
      conv = mono_bit ? st_r.fg : st_r.bg;
    end
    st_nxt.out_valid = pix_valid;
    if (pix_valid) begin
      st_nxt.out.data = conv;
      st_nxt.out.x = pix_in.x;
      st_nxt.out.y = pix_in.y;
      st_nxt.out.supported = conv_ok;
      // (R19) (R20) Selected clip set gates the write
      st_nxt.out.write = conv_ok && (st_r.cmd[CLIP_SEL_BIT] ?
                         in_clip(st_r.clip1_min, st_r.clip1_max, pix_in.x, pix_in.y) :
                         in_clip(st_r.clip0_min, st_r.clip0_max, pix_in.x, pix_in.y));
    end else begin
      st_nxt.out.write = 1'b0;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Write to the source format register and its data phase
  sequence src_fmt_write_s;
    hsel && hready && htrans[1] && hwrite && (haddr == 32'(OFS_SRC_FMT)) ##1 1'b1;
  endsequence

  // Pixel accepted while a given source format stands
  sequence pix_from_s(logic [3:0] code);
    pix_valid && (sfmt == code);
  endsequence

  reserved_zero_a: assert property ( // (R23)
    src_fmt_write_s |=> (st_r.src_fmt[31:24] == 8'h00) && (st_r.src_fmt[15:14] == 2'b00))
    else $error("reserved source format bits not zero");

  tiled_stride_a: assert property ( // (R2)
    st_r.geom[SRC_TILED_BIT] && $stable(st_r.src_fmt) |=>
    src_stride == {7'h00, $past(st_r.src_fmt[6:0])})
    else $error("tiled stride not cut to seven bits");

  linear_stride_a: assert property ( // (R6)
    !st_r.geom[SRC_TILED_BIT] && (pack == PACK_NONE) |=> src_stride == $past(st_r.src_fmt[13:0]))
    else $error("unpacked stride not from stride field");

  dword_pack_a: assert property ( // (R7)
    !st_r.geom[SRC_TILED_BIT] && (pack == PACK_DWORD) |=>
    (src_stride[1:0] == 2'b00) && (16'(src_stride) >= $past(row_bytes)))
    else $error("dword packed stride misaligned");

  swizzle_both_a: assert property ( // (R5)
    host_valid && st_r.src_fmt[BYTE_SWZ_BIT] && st_r.src_fmt[WORD_SWZ_BIT] |=>
    swz_valid && swz_data == {$past(host_data[23:16]), $past(host_data[31:24]),
                              $past(host_data[7:0]), $past(host_data[15:8])})
    else $error("combined swizzle order wrong");

  msb_replicate_a: assert property ( // (R10)
    pix_from_s(SRC_RGB16) && (dfmt == DST_D24) |=>
    (pix_out.data[2:0] == pix_out.data[7:5]) && (pix_out.data[9:8] == pix_out.data[15:14]))
    else $error("msb replication wrong");

  narrow_a: assert property ( // (R11)
    pix_from_s(SRC_RGB32) && (dfmt == DST_D16) |=>
    pix_out.data == {16'h0000, $past(pix_in.data[23:19]), $past(pix_in.data[15:10]),
                     $past(pix_in.data[7:3])})
    else $error("narrowing wrong");

  zero_alpha_a: assert property ( // (R12)
    pix_valid && (sfmt != SRC_RGB32) && (sfmt != SRC_MONO) && (dfmt == DST_D32) |=>
    pix_out.data[31:24] == 8'h00)
    else $error("alpha not zero");

  mono_color_a: assert property ( // (R17)
    pix_from_s(SRC_MONO) && (pix_in.idx == 5'd0) |=>
    pix_out.data == ($past(pix_in.data[7]) ? $past(st_r.fg) : $past(st_r.bg)))
    else $error("mono leftmost pixel wrong");

  d8_refuse_a: assert property ( // (R15)
    pix_from_s(SRC_RGB16) && (dfmt == DST_D8) |=> out_valid && !pix_out.supported && !pix_out.write)
    else $error("8bpp destination accepted 16bpp");

  clip_window_a: assert property ( // (R20)
    out_valid && pix_out.write && $stable(st_r.clip0_min) && !st_r.cmd[CLIP_SEL_BIT] |->
    (pix_out.x >= st_r.clip0_min[11:0]) && (pix_out.y >= st_r.clip0_min[27:16]))
    else $error("write below clip minimum");

endmodule

/* File: verif/host_model.sv */
`timescale 1ns/1ps
// Host side: AHB-Lite master plus host-port word source
module host_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic host_valid,
  output logic [31:0] host_data
);
  // Idle bus and quiet host port at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    host_valid = 1'b0;
    host_data = 32'h00000000;
  end
  // One single word transfer: address phase, then data phase
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    // Hold address phase until ready
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    // Hold data phase until ready
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    // Released data shows the inverse, not a stale value
    hwdata <= ~d;
  endtask
  // One host-port word, then the port goes quiet
  task push(input logic [31:0] d);
    @(posedge hclk);
    host_valid <= 1'b1;
    host_data <= d;
    @(posedge hclk);
    host_valid <= 1'b0;
    host_data <= ~d;
  endtask
endmodule

/* File: verif/test_blit_surface_format_clip.sv */
`timescale 1ns/1ps
// Self-checking bench for format, swizzle, stride and clip logic
module test_blit_surface_format_clip;
  import blit_fmt_pkg::*;
  // Conversion row: formats, input word, expected pixel
  typedef struct packed {
    logic [3:0] s;
    logic [2:0] d;
    logic [31:0] din;
    logic [4:0] idx;
    logic [31:0] dout;
    logic w;
  } conv_t;
  // Stride row: packing, format, width, tiled, expected
  typedef struct packed {
    logic [1:0] p;
    logic [3:0] s;
    logic [12:0] w;
    logic g;
    logic [13:0] e;
  } strd_t;
  // Clip row: select, place, expected write
  typedef struct packed {
    logic sel;
    logic [11:0] x;
    logic [11:0] y;
    logic w;
  } clip_t;
  localparam logic [31:0] FG = 32'h0011AA33; // Foreground colour
  localparam logic [31:0] BG = 32'h00665544; // Background colour
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic host_valid, swz_valid, pix_valid, out_valid;
  logic [31:0] haddr, hwdata, hrdata, host_data, swz_data;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [13:0] src_stride, dst_stride;
  pix_in_t pix_in;
  pix_out_t pix_out;
  int errors = 0; // Mismatch count
  int checked = 0; // Comparison count
  logic [31:0] msk [6] = '{MASK_SRC_FMT, MASK_DST_FMT, MASK_CLIP, MASK_CLIP, MASK_CLIP, MASK_CLIP};
  logic [31:0] swz [4] = '{32'h11223344, 32'h44332211, 32'h33441122, 32'h22114433};
  strd_t st [6] = '{'{2'h0, SRC_RGB24, 13'h3, 1'b0, 14'h3FFF},
    '{2'h1, SRC_RGB24, 13'h3, 1'b0, 14'h0009}, '{2'h2, SRC_RGB24, 13'h3, 1'b0, 14'h000A},
    '{2'h3, SRC_RGB24, 13'h3, 1'b0, 14'h000C}, '{2'h3, SRC_MONO, 13'hD, 1'b0, 14'h0004},
    '{2'h0, SRC_RGB24, 13'h3, 1'b1, 14'h007F}};
  conv_t cv [18] = '{'{SRC_RGB16, DST_D32, 32'h00008410, 5'h00, 32'h00848284, 1'b1},
    '{SRC_RGB16, DST_D24, 32'h00008410, 5'h00, 32'h00848284, 1'b1},
    '{SRC_RGB32, DST_D16, 32'hAA848284, 5'h00, 32'h00008410, 1'b1},
    '{SRC_RGB24, DST_D32, 32'hFF123456, 5'h00, 32'h00123456, 1'b1},
    '{SRC_RGB32, DST_D32, 32'hAB123456, 5'h00, 32'hAB123456, 1'b1},
    '{SRC_RGB32, DST_D24, 32'hAB123456, 5'h00, 32'h00123456, 1'b1},
    '{SRC_PAL8, DST_D8, 32'h0000005A, 5'h00, 32'h0000005A, 1'b1},
    '{SRC_RGB16, DST_D8, 32'h00008410, 5'h00, 32'h00000000, 1'b0},
    '{4'h2, DST_D32, 32'h00008410, 5'h00, 32'h00000000, 1'b0},
    '{SRC_RGB32, 3'h2, 32'h00123456, 5'h00, 32'h00000000, 1'b0},
    '{SRC_MONO, DST_D32, 32'h00000080, 5'h00, FG, 1'b1},
    '{SRC_MONO, DST_D32, 32'h00000080, 5'h01, BG, 1'b1},
    '{SRC_MONO, DST_D32, 32'h00000100, 5'h0F, FG, 1'b1},
    '{SRC_UYVY, DST_D32, 32'h1080EB80, 5'h00, 32'h00FFFFFF, 1'b1},
    '{SRC_UYVY, DST_D32, 32'h1080EB80, 5'h01, 32'h00000000, 1'b1},
    '{SRC_YUYV, DST_D32, 32'h801080EB, 5'h00, 32'h00FFFFFF, 1'b1},
    '{SRC_YUYV, DST_D32, 32'h801080EB, 5'h01, 32'h00000000, 1'b1},
    '{SRC_UYVY, DST_D16, 32'h1080EB80, 5'h00, 32'h0000FFFF, 1'b1}};
  clip_t cl [13] = '{'{1'b0, 12'h2, 12'h3, 1'b1}, '{1'b0, 12'h5, 12'h6, 1'b1},
    '{1'b0, 12'h6, 12'h6, 1'b0}, '{1'b0, 12'h5, 12'h7, 1'b0}, '{1'b0, 12'h1, 12'h3, 1'b0},
    '{1'b0, 12'h2, 12'h2, 1'b0}, '{1'b0, 12'hA, 12'hA, 1'b0}, '{1'b1, 12'hA, 12'hA, 1'b1},
    '{1'b1, 12'hB, 12'hB, 1'b1}, '{1'b1, 12'hC, 12'hB, 1'b0}, '{1'b1, 12'hB, 12'hC, 1'b0},
    '{1'b1, 12'h2, 12'h3, 1'b0}, '{1'b1, 12'h9, 12'hA, 1'b0}};

  // Zero wait-state slave drives the bus ready
  assign hready = hreadyout;

  // Clock at 40 MHz
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // Host partner: registers and host-port words
  host_model host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .host_valid(host_valid), .host_data(host_data));

  blit_surface_format_clip dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .host_valid(host_valid), .host_data(host_data), .swz_valid(swz_valid),
    .swz_data(swz_data), .pix_valid(pix_valid), .pix_in(pix_in), .out_valid(out_valid),
    .pix_out(pix_out), .src_stride(src_stride), .dst_stride(dst_stride));

  // Compare and count
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // Register write
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  // Register read and compare
  task rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h00000000, q);
    chk("read data", e, q);
  endtask
  // One source pixel, result looked at one cycle later
  task pix(input logic [31:0] d, input logic [4:0] i, input logic [11:0] x, input logic [11:0] y);
    @(posedge hclk);
    pix_valid <= 1'b1;
    pix_in <= {d, i, x, y};
    @(posedge hclk);
    pix_valid <= 1'b0;
    pix_in <= {~d, i, x, y};
    @(negedge hclk);
    chk("out valid", 32'h1, {31'h0, out_valid});
  endtask
  // Verdict and end of run
  task end_sim;
    $display("checks %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    hresetn = 1'b0;
    pix_valid = 1'b0;
    pix_in = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // Whole map reads zero after reset
    for (int a = 0; a <= 40; a += 4) rdc(32'(a), 32'h00000000);
    // Reserved bits dropped on write
    for (int k = 0; k < 6; k++) begin
      wr(32'(4 * k), 32'hFFFFFFFF);
      rdc(32'(4 * k), msk[k]);
    end
    // Unmapped places read zero
    wr(32'h00001000, 32'hFFFFFFFF);
    rdc(32'h00001000, 32'h00000000);
    rdc(32'h0000002C, 32'h00000000);
    // Host-port swizzle in all four modes
    for (int k = 0; k < 4; k++) begin
      wr({20'h0, OFS_SRC_FMT}, {10'h000, k[1:0], 20'h00000});
      host.push(32'h11223344);
      @(negedge hclk);
      chk("swizzle valid", 32'h1, {31'h0, swz_valid});
      chk("swizzle", swz[k], swz_data);
    end
    // Source stride: field, packing, tiling; tiled rows never packed
    foreach (st[k]) begin
      wr({20'h0, OFS_GEOMETRY}, {15'h0000, st[k].g, 3'h0, st[k].w});
      wr({20'h0, OFS_SRC_FMT}, {8'h00, st[k].p, 2'h0, st[k].s, 2'h0, 14'h3FFF});
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      chk("source stride", {18'h0, st[k].e}, {18'h0, src_stride});
    end
    // Destination stride tiled, then linear, then status
    wr({20'h0, OFS_GEOMETRY}, {14'h0000, 1'b1, 17'h00000});
    wr({20'h0, OFS_DST_FMT}, {13'h0000, DST_D32, 16'h3FFF});
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("dest stride", 32'h0000007F, {18'h0, dst_stride});
    wr({20'h0, OFS_GEOMETRY}, 32'h00000000);
    repeat (2) @(posedge hclk);
    rdc({20'h0, OFS_STRIDE_STAT}, 32'h3FFF3FFF);
    // Wide clip window and colours for conversions
    wr({20'h0, OFS_CLIP0_MIN}, 32'h00000000);
    wr({20'h0, OFS_CLIP0_MAX}, 32'h01000100);
    wr({20'h0, OFS_COMMAND}, 32'h00000000);
    wr({20'h0, OFS_FG_COLOR}, FG);
    wr({20'h0, OFS_BG_COLOR}, BG);
    // Conversion table; YUV rows keep a zero stride field
    foreach (cv[k]) begin
      wr({20'h0, OFS_SRC_FMT}, {12'h000, cv[k].s, 16'h0000});
      wr({20'h0, OFS_DST_FMT}, {13'h0000, cv[k].d, 16'h0000});
      pix(cv[k].din, cv[k].idx, 12'h005, 12'h005);
      chk("write", {31'h0, cv[k].w}, {31'h0, pix_out.write});
      if (cv[k].w === 1'b1) chk("pixel", cv[k].dout, pix_out.data);
    end
    // Two clip windows, edges on both sides
    wr({20'h0, OFS_SRC_FMT}, {12'h000, SRC_RGB32, 16'h0000});
    wr({20'h0, OFS_DST_FMT}, {13'h0000, DST_D32, 16'h0000});
    wr({20'h0, OFS_CLIP0_MIN}, 32'h00030002);
    wr({20'h0, OFS_CLIP0_MAX}, 32'h00070006);
    wr({20'h0, OFS_CLIP1_MIN}, 32'h000A000A);
    wr({20'h0, OFS_CLIP1_MAX}, 32'h000C000C);
    foreach (cl[k]) begin
      wr({20'h0, OFS_COMMAND}, {31'h0, cl[k].sel});
      pix(32'h00123456, 5'h00, cl[k].x, cl[k].y);
      chk("clip write", {31'h0, cl[k].w}, {31'h0, pix_out.write});
    end
    // Second reset in mid-run clears the registers
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc({20'h0, OFS_CLIP0_MIN}, 32'h00000000);
    chk("out valid", 32'h0, {31'h0, out_valid});
    end_sim;
  end

  // Watchdog against a hung handshake
  initial begin
    #(25 * 5000);
    errors++;
    end_sim;
  end
endmodule
